// *** src/sfb_dev.sv ***
// Device end: select qualification, serial shifting, pause and address decode.
// Assumes a host on the same interface; link logic runs on the serial clock.
// Behaviour
// - Works with clock idling low or high.
// - Inputs sampled on each rising clock edge.
// - Outputs change after each falling clock edge.
// - Dual reads use two bidirectional data lines.
// - Quad reads use four data lines.
// - Quad reads reuse protect and pause pins.
// - Quad reads need the quad enable bit.
// - First selection needs a select falling edge.
// - Power-on reset ignores instructions, then resets.
// - Standby only when deselected and not busy.
// - Pause floats output, ignores input and clock.
// - Host keeps select low during pause.
// - Pause starts when pause falls, clock low.
// - Pause ends when pause rises, clock low.
// - Pause freezes counters and instruction phase.
// - Deselect during pause abandons the transfer.
// - 64-kilobyte blocks from address bits 21..16.
// - Address bit 15 picks the half block.
// - 4-kilobyte sectors from address bits 21..12.
// - Deselected device ignores inputs, floats outputs.
// - Pause falling with clock high waits for low.
// - Pause never stops a running internal cycle.
`timescale 1ns/100ps
module sfb_dev
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    sfb_link_if.dev link,
    input wire logic quad_enable_i,
    input wire logic busy_i,
    input wire logic [sfb_pkg::WORD_BITS-1:0] rd_data_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_o,
    output logic [sfb_pkg::ADDR_BITS-1:0] addr_o,
    output logic [sfb_pkg::ARRAY_MSB-sfb_pkg::BLOCK_LSB:0] block_o,
    output logic [sfb_pkg::ARRAY_MSB-sfb_pkg::HALF_LSB:0] half_block_o,
    output logic [sfb_pkg::ARRAY_MSB-sfb_pkg::SECTOR_LSB:0] sector_o,
    output logic standby_o
);
    import sfb_pkg::*;

    // Per-frame state, cleared whenever select is high.
    typedef struct packed {
        sfb_phase_t ph;
        logic [4:0] cnt;
        logic [7:0] cmd;
        logic [23:0] addr;
        sfb_op_t op;
    } sfb_frm_t;

    // Survives deselect: hands the decoded request to the core side.
    typedef struct packed {
        logic tgl;
        logic qe_s1;
        logic qe_s2;
        logic [7:0] cmd;
        logic [23:0] addr;
    } sfb_mbox_t;

    // Output stage updated on the falling clock edge.
    typedef struct packed {
        logic [4:0] ptr;
        logic [3:0] dout;
        logic [3:0] mask;
        logic drive;
        logic pause;
    } sfb_out_t;

    // Core clock side.
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic armed;
        logic [31:0] word;
        logic ev_s1;
        logic ev_s2;
        logic ev_seen;
        logic valid;
        logic [7:0] cmd;
        logic [23:0] addr;
        logic standby;
    } sfb_core_t;

    sfb_frm_t frm_reg;
    sfb_frm_t frm_next;
    sfb_mbox_t mb_reg;
    sfb_mbox_t mb_next;
    sfb_out_t out_reg;
    sfb_out_t out_next;
    sfb_core_t core_reg;
    sfb_core_t core_next;
    sfb_op_t op_now;
    logic quad_lines;
    logic hold_now;
    logic pause_eff;
    logic link_rst;
    logic mbox_rst;
    logic [31:0] addr_sh;
    logic [31:0] word_sh;

    // Select high or an unarmed device resets the frame and output stage; the mailbox clears only when unarmed.
    assign link_rst = link.cs_n | ~core_reg.armed;
    assign mbox_rst = ~core_reg.armed;

    // Once a quad read is decoded the pause pin is a data line.
    assign quad_lines = frm_reg.op.quad && frm_reg.ph != PH_CMD;
    assign hold_now = !quad_lines && !link.io[3];

    // With the clock low the pin acts at once; with it high the state
    // latched at the last falling edge holds until the clock goes low.
    assign pause_eff = link.sclk ? out_reg.pause : hold_now;

    // Rising-edge side: command, address and dummy phases.
    always_comb
    begin
        frm_next = frm_reg;
        mb_next = mb_reg;
        mb_next.qe_s1 = quad_enable_i;
        mb_next.qe_s2 = mb_reg.qe_s1;
        op_now = sfb_decode({frm_reg.cmd[6:0], link.io[0]});
        addr_sh = sfb_shift_in({8'h00, frm_reg.addr}, link.io, frm_reg.op.addr_w);
        // A paused transfer keeps every counter and phase as it was.
        if (!hold_now)
        begin
            case (frm_reg.ph)
                PH_CMD:
                begin
                    frm_next.cmd = {frm_reg.cmd[6:0], link.io[0]};
                    frm_next.cnt = frm_reg.cnt + 5'h01;
                    if (frm_reg.cnt == 5'(CMD_BITS - 1))
                    begin
                        frm_next.op = op_now;
                        frm_next.cnt = 5'h00;
                        frm_next.ph = PH_IGNORE;
                        if (op_now.known && (!op_now.quad || mb_reg.qe_s2))
                            frm_next.ph = PH_ADDR;
                        else if (!op_now.known)
                        begin
                            // Other instructions go up with no address.
                            mb_next.tgl = ~mb_reg.tgl;
                            mb_next.cmd = frm_next.cmd;
                            mb_next.addr = 24'h000000;
                        end
                    end
                end
                PH_ADDR:
                begin
                    frm_next.addr = addr_sh[23:0];
                    frm_next.cnt = frm_reg.cnt + 5'h01;
                    if (frm_reg.cnt == 5'(sfb_beats(frm_reg.op.addr_w, ADDR_BITS) - 7'h01))
                    begin
                        mb_next.tgl = ~mb_reg.tgl;
                        mb_next.cmd = frm_reg.cmd;
                        mb_next.addr = addr_sh[23:0];
                        frm_next.cnt = 5'h00;
                        frm_next.ph = (frm_reg.op.dummy == 4'h0) ? PH_DATA : PH_DUMMY;
                    end
                end
                PH_DUMMY:
                begin
                    // Lines 0 and 1 stay released by both ends here; outside quad reads the host drives lines 2 and 3.
                    frm_next.cnt = frm_reg.cnt + 5'h01;
                    if (frm_reg.cnt == {1'b0, frm_reg.op.dummy - 4'h1})
                        frm_next.ph = PH_DATA;
                end
                PH_DATA: frm_next.ph = PH_DATA;
                PH_IGNORE: frm_next.ph = PH_IGNORE;
                default: frm_next.ph = PH_IGNORE;
            endcase
        end
    end

    // Falling-edge side: next beat of read data, MSB first.
    always_comb
    begin
        out_next = out_reg;
        out_next.pause = hold_now;
        word_sh = core_reg.word << out_reg.ptr;
        if (frm_reg.ph == PH_DATA && !hold_now)
        begin
            out_next.drive = 1'b1;
            out_next.ptr = out_reg.ptr + 5'(frm_reg.op.data_w);
            case (frm_reg.op.data_w)
                W2:
                begin
                    out_next.dout = {2'b00, word_sh[31:30]};
                    out_next.mask = 4'h3;
                end
                W4:
                begin
                    out_next.dout = word_sh[31:28];
                    out_next.mask = 4'hF;
                end
                default:
                begin
                    out_next.dout = {2'b00, word_sh[31], 1'b0};
                    out_next.mask = 4'h2;
                end
            endcase
        end
    end

    // Mode 0 and mode 3 both fit: a frame starts from reset at select low,
    // and a leading falling edge in mode 3 finds nothing to drive.
    always_ff @(posedge link.sclk or posedge link_rst)
    begin
        if (link_rst)
            frm_reg <= '{ph: PH_CMD, default: '0};
        else
            frm_reg <= frm_next;
    end

    // The toggle must not fall back on deselect, or the core would see a
    // false request; only power-on reset clears it.
    always_ff @(posedge link.sclk or posedge mbox_rst)
    begin
        if (mbox_rst)
            mb_reg <= '0;
        else
            mb_reg <= mb_next;
    end

    // Output stage register on the falling edge.
    always_ff @(negedge link.sclk or posedge link_rst)
    begin
        if (link_rst)
            out_reg <= '0;
        else
            out_reg <= out_next;
    end

    // Data lines float while deselected or paused; line 3 only carries data
    // in quad reads, where no pause exists, so it skips the pause gate.
    assign link.dev_out = out_reg.dout;
    assign link.dev_oe_n[2:0] = ~(out_reg.mask[2:0]
        & {3{out_reg.drive & ~pause_eff & ~link.cs_n}});
    assign link.dev_oe_n[3] = ~(out_reg.mask[3] & out_reg.drive & ~link.cs_n);

    // Core side: select synchroniser, arming, request capture and standby.
    always_comb
    begin
        core_next = core_reg;
        core_next.cs_s1 = link.cs_n;
        core_next.cs_s2 = core_reg.cs_s1;
        // Select must be seen high before any frame is honoured.
        if (core_reg.cs_s2)
            core_next.armed = 1'b1;
        // The read word is frozen while selected, so the link reads it safely.
        if (core_reg.cs_s2)
            core_next.word = rd_data_i;
        core_next.ev_s1 = mb_reg.tgl;
        core_next.ev_s2 = core_reg.ev_s1;
        core_next.ev_seen = core_reg.ev_s2;
        core_next.valid = core_reg.ev_s2 != core_reg.ev_seen;
        if (core_reg.ev_s2 != core_reg.ev_seen)
        begin
            core_next.cmd = mb_reg.cmd;
            core_next.addr = mb_reg.addr;
        end
        // A pause has no say here, so a running internal cycle carries on.
        core_next.standby = core_reg.cs_s2 && !busy_i;
    end

    // Core register; reset disarms the link until select is seen high.
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            core_reg <= '0;
        else
            core_reg <= core_next;
    end

    assign cmd_valid_o = core_reg.valid;
    assign cmd_o = core_reg.cmd;
    assign addr_o = core_reg.addr;
    assign block_o = core_reg.addr[ARRAY_MSB:BLOCK_LSB];
    assign half_block_o = core_reg.addr[ARRAY_MSB:HALF_LSB];
    assign sector_o = core_reg.addr[ARRAY_MSB:SECTOR_LSB];
    assign standby_o = core_reg.standby;
endmodule // sfb_dev

// *** src/sfb_host.sv ***
// Host end: issues one instruction per request and reads back one word.
// Assumes the device end on the same interface; makes the serial clock itself.
`timescale 1ns/100ps
module sfb_host
#(
    parameter int HALF_CYCLES = sfb_pkg::SCLK_HALF_CYCLES
)
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [7:0] opcode_i,
    input wire logic [sfb_pkg::ADDR_BITS-1:0] addr_i,
    input wire logic pause_i,
    output logic ready_o,
    output logic done_o,
    output logic [sfb_pkg::WORD_BITS-1:0] rd_data_o,
    sfb_link_if.host link
);
    import sfb_pkg::*;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SETUP = 3'b001,
        HS_LOW = 3'b010,
        HS_HIGH = 3'b011,
        HS_PAUSE = 3'b100,
        HS_TAIL = 3'b101
    } sfb_hstate_t;

    typedef struct packed {
        sfb_hstate_t st;
        logic [7:0] div;
        logic [6:0] idx;
        logic [7:0] opc;
        logic [23:0] addr;
        sfb_op_t op;
        logic [31:0] data;
        logic sclk;
        logic cs_n;
        logic [3:0] out;
        logic [3:0] oe_n;
        logic [3:0] io_s1;
        logic [3:0] io_s2;
        logic done;
    } sfb_host_t;

    sfb_host_t h_reg;
    sfb_host_t h_next;
    logic half_end;
    logic [6:0] end_addr;
    logic [6:0] end_dummy;
    logic [6:0] total;
    logic [31:0] sh;
    logic [3:0] nib;

    // Segment boundaries in clocks; an unknown code sends only its byte.
    always_comb
    begin
        end_addr = 7'(CMD_BITS);
        end_dummy = 7'(CMD_BITS);
        total = 7'(CMD_BITS);
        if (h_reg.op.known)
        begin
            end_addr = 7'(CMD_BITS) + sfb_beats(h_reg.op.addr_w, ADDR_BITS);
            end_dummy = end_addr + {3'h0, h_reg.op.dummy};
            total = end_dummy + sfb_beats(h_reg.op.data_w, WORD_BITS);
        end
    end

    // One sequencer for clock division, line driving and sampling.
    always_comb
    begin
        h_next = h_reg;
        h_next.done = 1'b0;
        h_next.io_s1 = link.io;
        h_next.io_s2 = h_reg.io_s1;
        half_end = h_reg.div == 8'(HALF_CYCLES - 1);
        h_next.div = half_end ? 8'h00 : h_reg.div + 8'h01;
        sh = {h_reg.addr, 8'h00} << (int'(h_reg.idx - 7'(CMD_BITS)) * int'(h_reg.op.addr_w));
        nib = (h_reg.op.data_w == W1) ? {3'h0, h_reg.io_s2[1]} : h_reg.io_s2;
        case (h_reg.st)
            HS_IDLE:
            begin
                h_next.div = 8'h00;
                h_next.idx = 7'h00;
                h_next.oe_n = 4'hF;
                if (start_i)
                begin
                    h_next.opc = opcode_i;
                    h_next.addr = addr_i;
                    h_next.op = sfb_decode(opcode_i);
                    h_next.cs_n = 1'b0;
                    h_next.st = HS_SETUP;
                end
            end
            HS_SETUP:
                if (half_end)
                    h_next.st = HS_LOW;
            HS_LOW:
            begin
                // Lines change only while the clock is low; released by default.
                h_next.oe_n = 4'hF;
                h_next.out = 4'hC;
                if (!h_reg.op.quad)
                    h_next.oe_n[3:2] = 2'b00;
                if (h_reg.idx < 7'(CMD_BITS))
                begin
                    h_next.out[0] = h_reg.opc[3'(7 - h_reg.idx)];
                    h_next.oe_n[0] = 1'b0;
                end
                else if (h_reg.idx < end_addr)
                begin
                    case (h_reg.op.addr_w)
                        W2:
                        begin
                            h_next.out[1:0] = sh[31:30];
                            h_next.oe_n[1:0] = 2'b00;
                        end
                        W4:
                        begin
                            h_next.out = sh[31:28];
                            h_next.oe_n = 4'h0;
                        end
                        default:
                        begin
                            h_next.out[0] = sh[31];
                            h_next.oe_n[0] = 1'b0;
                        end
                    endcase
                end
                if (half_end)
                begin
                    // Pausing only with the clock low makes entry take effect at once.
                    if (pause_i && !h_reg.op.quad)
                    begin
                        h_next.out[3] = 1'b0;
                        h_next.st = HS_PAUSE;
                    end
                    else
                    begin
                        h_next.sclk = 1'b1;
                        h_next.st = HS_HIGH;
                    end
                end
            end
            HS_PAUSE:
            begin
                h_next.div = 8'h00;
                if (!pause_i)
                begin
                    h_next.out[3] = 1'b1;
                    h_next.st = HS_LOW;
                end
            end
            HS_HIGH:
                if (half_end)
                begin
                    // Sample late in the high phase, after the synchroniser delay.
                    if (h_reg.idx >= end_dummy && h_reg.idx < total)
                        h_next.data = sfb_shift_in(h_reg.data, nib, h_reg.op.data_w);
                    h_next.sclk = 1'b0;
                    h_next.idx = h_reg.idx + 7'h01;
                    h_next.st = (h_reg.idx == total - 7'h01) ? HS_TAIL : HS_LOW;
                end
            HS_TAIL:
            begin
                h_next.oe_n = 4'hF;
                if (half_end)
                begin
                    h_next.cs_n = 1'b1;
                    h_next.done = 1'b1;
                    h_next.st = HS_IDLE;
                end
            end
            default: h_next.st = HS_IDLE;
        endcase
    end

    // State register; reset parks the link deselected with the clock low.
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            h_reg <= '{st: HS_IDLE, cs_n: 1'b1, oe_n: 4'hF, out: 4'hC, default: '0};
        else
            h_reg <= h_next;
    end

    assign ready_o = h_reg.st == HS_IDLE;
    assign done_o = h_reg.done;
    assign rd_data_o = h_reg.data;
    assign link.sclk = h_reg.sclk;
    assign link.cs_n = h_reg.cs_n;
    assign link.host_out = h_reg.out;
    assign link.host_oe_n = h_reg.oe_n;
endmodule // sfb_host

// *** src/sfb_link_if.sv ***
// Four shared data lines, select and serial clock between host and device.
// Each end gives value and active-low enable; lines resolve here with pull-ups.
`timescale 1ns/100ps
interface sfb_link_if;
    logic sclk;
    logic cs_n;
    logic [3:0] host_out;
    logic [3:0] host_oe_n;
    logic [3:0] dev_out;
    logic [3:0] dev_oe_n;
    logic [3:0] io;

    // An undriven line reads high, as the protect and pause pins are pulled up.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!dev_oe_n[i])
                io[i] = dev_out[i];
            else if (!host_oe_n[i])
                io[i] = host_out[i];
            else
                io[i] = 1'b1;
        end
    end

    modport dev (input sclk, input cs_n, input io, output dev_out, output dev_oe_n);
    modport host (output sclk, output cs_n, output host_out, output host_oe_n, input io);
endinterface

// *** src/sfb_pkg.sv ***
// Shared constants, types and helpers for both ends of the serial flash bus.
// Assumes one host and one device on a four-line link with a 24-bit address.
package sfb_pkg;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO = 8'hEB;
    localparam int CMD_BITS = 8;
    localparam int ADDR_BITS = 24;
    localparam int WORD_BITS = 32;
    localparam logic [3:0] DUMMY_FAST = 4'h8;
    localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
    localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
    localparam int BLOCK_LSB = 16;
    localparam int HALF_LSB = 15;
    localparam int SECTOR_LSB = 12;
    localparam int ARRAY_MSB = 21;
    localparam int SCLK_HALF_CYCLES = 4;
    localparam logic [2:0] W1 = 3'h1;
    localparam logic [2:0] W2 = 3'h2;
    localparam logic [2:0] W4 = 3'h4;

    typedef enum logic [2:0] {
        PH_CMD = 3'b000,
        PH_ADDR = 3'b001,
        PH_DUMMY = 3'b010,
        PH_DATA = 3'b011,
        PH_IGNORE = 3'b100
    } sfb_phase_t;

    typedef struct packed {
        logic known;
        logic quad;
        logic [2:0] addr_w;
        logic [2:0] data_w;
        logic [3:0] dummy;
    } sfb_op_t;

    // Line widths and dummy clocks of each read code; other codes are plain.
    function automatic sfb_op_t sfb_decode(input logic [7:0] op);
        sfb_op_t d;
        d = '{known: 1'b1, quad: 1'b0, addr_w: W1, data_w: W1, dummy: 4'h0};
        case (op)
            OP_READ: d.dummy = 4'h0;
            OP_FAST_READ: d.dummy = DUMMY_FAST;
            OP_DUAL_OUT:
            begin
                d.data_w = W2;
                d.dummy = DUMMY_FAST;
            end
            OP_DUAL_IO:
            begin
                d.addr_w = W2;
                d.data_w = W2;
                d.dummy = DUMMY_DUAL_IO;
            end
            OP_QUAD_OUT:
            begin
                d.quad = 1'b1;
                d.data_w = W4;
                d.dummy = DUMMY_FAST;
            end
            OP_QUAD_IO:
            begin
                d.quad = 1'b1;
                d.addr_w = W4;
                d.data_w = W4;
                d.dummy = DUMMY_QUAD_IO;
            end
            default: d.known = 1'b0;
        endcase
        return d;
    endfunction

    // Clocks needed to move a field of the given size at the given width.
    function automatic logic [6:0] sfb_beats(input logic [2:0] w, input int bits);
        return 7'(bits / int'(w));
    endfunction

    // Shift a value left by one beat; a single line enters through bit 0.
    function automatic logic [31:0] sfb_shift_in(input logic [31:0] v,
        input logic [3:0] nib, input logic [2:0] w);
        case (w)
            W2: return {v[29:0], nib[1:0]};
            W4: return {v[27:0], nib};
            default: return {v[30:0], nib[0]};
        endcase
    endfunction
endpackage

// *** tb/sfb_link_sva.sv ***
// Checker for the link that joins the host and device ends.
// Sees only link signals, with the core clock and reset.
`timescale 1ns/100ps
module sfb_link_sva
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] host_oe_n,
    input wire logic [3:0] dev_out,
    input wire logic [3:0] dev_oe_n,
    input wire logic [3:0] io
);
    // The core clock outruns the serial clock, so it sees every link edge.
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    desel_float_a: assert property (cs_n |-> dev_oe_n == 4'hF)
        else $error("device drives while deselected");
    no_contend_a: assert property ((~dev_oe_n & ~host_oe_n) == 4'h0)
        else $error("both ends drive one line");
    rise_hold_a: assert property ((!cs_n && sclk && $past(sclk && !cs_n))
        |-> $stable(dev_oe_n) && $stable(dev_out | dev_oe_n))
        else $error("device output moved while serial clock high");
    pause_float_a: assert property ((!cs_n && !io[3] && !sclk && dev_oe_n[3])[*3]
        |-> &dev_oe_n[2:0])
        else $error("device drives during pause");
    clk_idle_a: assert property ((cs_n && $past(cs_n)) |-> $stable(sclk))
        else $error("serial clock moved outside a frame");
    dual_pair_a: assert property (!dev_oe_n[0] |-> !dev_oe_n[1])
        else $error("line 0 driven without line 1");
    quad_all_a: assert property (!dev_oe_n[2] |-> dev_oe_n == 4'h0)
        else $error("upper lines driven without all four");
    // Outside quad reads the host keeps driving the protect and pause lines.
    // So only the lines the device takes must have been free the cycle before.
    start_free_a: assert property ($fell(&dev_oe_n)
        |-> ($past(host_oe_n) | dev_oe_n) == 4'hF)
        else $error("device drives before host released");
    sel_c: cover property ($fell(cs_n));
    quad_c: cover property (!dev_oe_n[3]);
    dual_c: cover property (!dev_oe_n[0] && dev_oe_n[2]);
    pause_c: cover property (!cs_n && !io[3] && dev_oe_n[3] && !sclk);
endmodule // sfb_link_sva

// *** tb/tb_top.sv ***
// Testbench joining host and device ends over one link.
// Drives both core sides at the falling edge and judges the results.
`timescale 1ns/100ps
module tb_top;
    import sfb_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic pause = 1'b0;
    logic qe = 1'b1;
    logic busy = 1'b0;
    logic [7:0] op = 8'h00;
    logic [23:0] adr = 24'h000000;
    logic [31:0] word = 32'hA5C30F96;
    logic ready, done, cvld, stby;
    logic [31:0] rd;
    logic [7:0] cmd;
    logic [23:0] cadr;
    logic [5:0] blk;
    logic [6:0] half;
    logic [9:0] sec;
    int mismatches = 0;
    int check_count = 0;
    int pulses = 0;
    sfb_link_if link();
    sfb_host u_sfb_host(.core_clk_i(clk), .rst_n_i(rst_n), .start_i(start), .opcode_i(op),
        .addr_i(adr), .pause_i(pause), .ready_o(ready), .done_o(done), .rd_data_o(rd),
        .link(link));
    sfb_dev u_sfb_dev(.core_clk_i(clk), .rst_n_i(rst_n), .link(link), .quad_enable_i(qe),
        .busy_i(busy), .rd_data_i(word), .cmd_valid_o(cvld), .cmd_o(cmd), .addr_o(cadr),
        .block_o(blk), .half_block_o(half), .sector_o(sec), .standby_o(stby));
    sfb_link_sva u_sfb_link_sva(.core_clk_i(clk), .rst_n_i(rst_n), .sclk(link.sclk),
        .cs_n(link.cs_n), .host_oe_n(link.host_oe_n), .dev_out(link.dev_out),
        .dev_oe_n(link.dev_oe_n), .io(link.io));

    // Free-running core clock of 40 ns.
    always #20 clk = ~clk;

    // Counting requests lets a refused frame show up as a missing pulse.
    always @(posedge clk)
        if (cvld === 1'b1)
            pulses <= pulses + 1;

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One whole frame; the wait is bounded so a hang ends the run.
    task automatic xfer(input logic [7:0] o, input logic [23:0] a, input int inc);
        int n;
        int p0;
        p0 = pulses;
        @(negedge clk);
        op = o;
        adr = a;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (n = 0; n < 4000 && done !== 1'b1; n++)
            @(negedge clk);
        if (n == 4000)
        begin
            mismatches++;
            give_verdict();
        end
        repeat (4) @(negedge clk);
        chk("requests", 32'(p0 + inc), 32'(pulses));
        chk("ready", 32'h1, 32'(ready));
    endtask

    task automatic t_reads();
        logic [7:0] c [6] = '{OP_READ, OP_FAST_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT,
            OP_QUAD_IO};
        logic [23:0] a [6] = '{24'h3FFFFF, 24'h008000, 24'h3E7ABC, 24'h00F123, 24'h010000,
            24'h2A5F00};
        for (int i = 0; i < 6; i++)
        begin
            word = 32'h12345678 ^ {4{c[i]}};
            xfer(c[i], a[i], 1);
            chk("data", word, rd);
            chk("cmd", 32'(c[i]), 32'(cmd));
            chk("addr", 32'(a[i]), 32'(cadr));
            chk("block", 32'(a[i][21:16]), 32'(blk));
            chk("half", 32'(a[i][21:15]), 32'(half));
            chk("sector", 32'(a[i][21:12]), 32'(sec));
        end
        $display("t_reads done");
    endtask

    task automatic t_other();
        qe = 1'b0;
        xfer(OP_QUAD_IO, 24'h123456, 0);
        chk("pulled up", 32'hFFFFFFFF, rd);
        xfer(8'h06, 24'h3FFFFF, 1);
        chk("other cmd", 32'h00000006, 32'(cmd));
        chk("other addr", 32'h00000000, 32'(cadr));
        $display("t_other done");
    endtask

    // Pauses land mid-address and mid-data; the word must still arrive intact.
    task automatic t_pause();
        word = 32'hC0FFEE11;
        fork
            xfer(OP_FAST_READ, 24'h0ABCDE, 1);
            begin
                repeat (100) @(negedge clk);
                pause = 1'b1;
                repeat (60) @(negedge clk);
                pause = 1'b0;
                repeat (240) @(negedge clk);
                pause = 1'b1;
                repeat (30) @(negedge clk);
                chk("standby paused", 32'h0, 32'(stby));
                repeat (30) @(negedge clk);
                pause = 1'b0;
            end
        join
        chk("paused data", word, rd);
        chk("paused addr", 32'h000ABCDE, 32'(cadr));
        $display("t_pause done");
    endtask

    task automatic t_standby();
        busy = 1'b1;
        repeat (6) @(negedge clk);
        chk("standby busy", 32'h0, 32'(stby));
        busy = 1'b0;
        repeat (6) @(negedge clk);
        chk("standby idle", 32'h1, 32'(stby));
        $display("t_standby done");
    endtask

    // Reset in mid-frame; the next frame must start from a clean link state.
    task automatic t_reset();
        @(negedge clk);
        op = OP_READ;
        adr = 24'h123456;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (40) @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        chk("reset standby", 32'h0, 32'(stby));
        rst_n = 1'b1;
        word = 32'h0F1E2D3C;
        repeat (6) @(negedge clk);
        xfer(OP_DUAL_IO, 24'h3F8001, 1);
        chk("reset data", word, rd);
        chk("reset addr", 32'h003F8001, 32'(cadr));
        $display("t_reset done");
    endtask

    // Main sequence: reset for 20 cycles, let the device arm, run scenarios.
    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        t_reads();
        t_other();
        t_pause();
        t_standby();
        t_reset();
        give_verdict();
    end
endmodule // tb_top
